// *** ivme_top.sv ***
module ivme_top import ivme_pkg::*; #(
	parameter int MOT_N   = 8,
	parameter int NUM_IRQ = 16,
	parameter int PC_W    = 16,
	parameter int FLAG_W  = 8
) (
	// clock and reset
	input  wire logic              MCLK_I,
	input  wire logic              SYS_RST_I,
	// command frames
	input  wire logic              CMD_VALID_I,
	output logic                   CMD_READY_O,
	input  wire logic [7:0]        CMD_OPCODE_I,
	input  wire logic [7:0]        CMD_TYPE_I,
	input  wire logic [VAL_W-1:0]  CMD_VALUE_I,
	input  wire logic              CMD_DIRECT_I,
	// reply frames
	output logic                   REPLY_VALID_O,
	input  wire logic              REPLY_READY_I,
	output logic [7:0]             REPLY_STATUS_O,
	output logic [7:0]             REPLY_CMD_O,
	output logic [VAL_W-1:0]       REPLY_VALUE_O,
	// extension ops
	output logic                   EXT_STB_O,
	input  wire logic [VAL_W-1:0]  EXT_RESULT_I,
	// interrupt sources and program engine
	input  wire logic [NUM_IRQ-1:0] IRQ_EVT_I,
	input  wire logic              PROG_RUN_I,
	output logic                   IRQ_JUMP_O,
	output logic [PC_W-1:0]        IRQ_JUMP_PC_O,
	output logic                   IN_HANDLER_O,
	// context save and restore
	input  wire logic [VAL_W-1:0]  CTX_ACCU_I,
	input  wire logic [VAL_W-1:0]  CTX_X_I,
	input  wire logic [FLAG_W-1:0] CTX_FLAGS_I,
	input  wire logic [PC_W-1:0]   CTX_PC_I,
	output logic                   CTX_RESTORE_O,
	output logic [VAL_W-1:0]       CTX_ACCU_O,
	output logic [VAL_W-1:0]       CTX_X_O,
	output logic [FLAG_W-1:0]      CTX_FLAGS_O,
	output logic [PC_W-1:0]        CTX_PC_O,
	// motion engine
	input  wire logic              MVP_STB_I,
	input  wire logic [MOT_N-1:0]  MVP_MASK_I,
	input  wire logic [MOT_N-1:0]  MOT_REACHED_I
);
	localparam int IW = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;

	logic                take, known, is_en, is_dis, is_define_handler_entry, is_handler_return, is_ext, is_reach;
	logic                typ_ok, enter, handler_return_now;
	logic [IW-1:0]       tidx, sel;
	logic [NUM_IRQ-1:0]  cand, sel_oh;
	logic [PC_W-1:0]     vec_q [NUM_IRQ];
	logic [PC_W-1:0]     vec_d [NUM_IRQ];
	logic [NUM_IRQ-1:0]  vdef_q, vdef_d, ien_q, ien_d, ipend_q, ipend_d;
	logic                gen_q, gen_d;
	ivme_hstate_t        hs_q, hs_d;
	logic                jump_q, jump_d, rest_q, rest_d;
	logic [PC_W-1:0]     jpc_q, jpc_d, spc_q, spc_d;
	logic [VAL_W-1:0]    sacc_q, sacc_d, sx_q, sx_d;
	logic [FLAG_W-1:0]   sfl_q, sfl_d;
	logic                rv_q, rv_d;
	logic [7:0]          rst_q, rst_d, rcmd_q, rcmd_d;
	logic [VAL_W-1:0]    rval_q, rval_d;
	logic [MOT_N-1:0]    epend_q, epend_d, sent;

	ivme_evt_if #(.MOT_N(MOT_N)) ev ();

	ivme_evt_track #(.MOT_N(MOT_N)) u_track (
		.clk_i (MCLK_I),
		.rst_i (SYS_RST_I),
		.ev    (ev.track)
	);

	// ==========================================================
	// command decode
	assign CMD_READY_O = !rv_q;
	assign take        = CMD_VALID_I && CMD_READY_O;
	assign tidx        = CMD_TYPE_I[IW-1:0];
	assign typ_ok      = 32'(CMD_TYPE_I) < NUM_IRQ;

	always_comb begin
		is_en    = 1'b0;
		is_dis   = 1'b0;
		is_define_handler_entry  = 1'b0;
		is_handler_return  = 1'b0;
		is_ext   = 1'b0;
		is_reach = 1'b0;
		if (CMD_OPCODE_I == OP_IRQ_ENABLE)
			is_en = 1'b1;
		else if (CMD_OPCODE_I == OP_IRQ_DISABLE)
			is_dis = 1'b1;
		else if (CMD_OPCODE_I == OP_DEF_ENTRY)
			is_define_handler_entry = 1'b1;
		else if (CMD_OPCODE_I == OP_HANDLER_RET)
			is_handler_return = 1'b1;
		else if (CMD_OPCODE_I >= OP_EXT_FIRST && CMD_OPCODE_I <= OP_EXT_LAST)
			is_ext = 1'b1;
		else if (CMD_OPCODE_I == OP_REACH_REQ)
			is_reach = 1'b1;
	end

	assign known     = is_en | is_dis | is_define_handler_entry | is_handler_return | is_ext | is_reach;
	assign EXT_STB_O = take && is_ext;
	assign handler_return_now  = take && is_handler_return && hs_q == HS_HANDLER;

	// ==========================================================
	// interrupt selection, lowest number first
	assign cand = ipend_q & ien_q & vdef_q;

	always_comb begin
		sel    = '0;
		sel_oh = '0;
		for (int i = NUM_IRQ - 1; i >= 0; i--) begin
			if (cand[i]) begin
				sel    = IW'(i);
				sel_oh = NUM_IRQ'(1) << i;
			end
		end
	end

	// an interrupt never splits a program command or a return
	assign enter = gen_q && hs_q == HS_NORMAL && PROG_RUN_I && |cand
		&& !(take && !CMD_DIRECT_I) && !handler_return_now;

	// ==========================================================
	// vectors, enables, handler context
	always_comb begin
		vec_d   = vec_q;
		vdef_d  = vdef_q;
		ien_d   = ien_q;
		gen_d   = gen_q;
		hs_d    = hs_q;
		jump_d  = 1'b0;
		rest_d  = 1'b0;
		jpc_d   = jpc_q;
		spc_d   = spc_q;
		sacc_d  = sacc_q;
		sx_d    = sx_q;
		sfl_d   = sfl_q;
		ipend_d = ipend_q;
		if (take && is_define_handler_entry && typ_ok) begin
			vec_d[tidx]  = CMD_VALUE_I[PC_W-1:0];
			vdef_d[tidx] = 1'b1;
		end
		if (take && (is_en || is_dis)) begin
			if (CMD_TYPE_I == IRQ_GLOBAL)
				gen_d = is_en;
			else if (typ_ok)
				ien_d[tidx] = is_en;
		end
		if (handler_return_now) begin
			hs_d   = HS_NORMAL;
			rest_d = 1'b1;
		end
		if (enter) begin
			hs_d    = HS_HANDLER;
			jump_d  = 1'b1;
			jpc_d   = vec_q[sel];
			spc_d   = CTX_PC_I;
			sacc_d  = CTX_ACCU_I;
			sx_d    = CTX_X_I;
			sfl_d   = CTX_FLAGS_I;
			ipend_d = ipend_q & ~sel_oh;
		end
		ipend_d = ipend_d | IRQ_EVT_I;
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			for (int i = 0; i < NUM_IRQ; i++)
				vec_q[i] <= PC_W'(VAL_RST);
			vdef_q  <= '0;
			ien_q   <= '0;
			gen_q   <= GLOBAL_EN_RST;
			hs_q    <= HS_NORMAL;
			jump_q  <= 1'b0;
			rest_q  <= 1'b0;
			jpc_q   <= PC_W'(VAL_RST);
			spc_q   <= PC_W'(VAL_RST);
			sacc_q  <= VAL_RST;
			sx_q    <= VAL_RST;
			sfl_q   <= FLAG_W'(VAL_RST);
			ipend_q <= '0;
		end else begin
			vec_q   <= vec_d;
			vdef_q  <= vdef_d;
			ien_q   <= ien_d;
			gen_q   <= gen_d;
			hs_q    <= hs_d;
			jump_q  <= jump_d;
			rest_q  <= rest_d;
			jpc_q   <= jpc_d;
			spc_q   <= spc_d;
			sacc_q  <= sacc_d;
			sx_q    <= sx_d;
			sfl_q   <= sfl_d;
			ipend_q <= ipend_d;
		end
	end

	assign IRQ_JUMP_O    = jump_q;
	assign IRQ_JUMP_PC_O = jpc_q;
	assign IN_HANDLER_O  = hs_q == HS_HANDLER;
	assign CTX_RESTORE_O = rest_q;
	assign CTX_ACCU_O    = sacc_q;
	assign CTX_X_O       = sx_q;
	assign CTX_FLAGS_O   = sfl_q;
	assign CTX_PC_O      = spc_q;

	// ==========================================================
	// target reached tracking
	assign ev.arm         = take && is_reach;
	assign ev.arm_mask    = CMD_VALUE_I[MOT_N-1:0];
	assign ev.arm_persist = CMD_TYPE_I == REACH_PERSIST;
	assign ev.mvp_stb     = MVP_STB_I;
	assign ev.mvp_mask    = MVP_MASK_I;
	assign ev.reached     = MOT_REACHED_I;

	// ==========================================================
	// reply slot; the direct-mode answer wins over an arrival reply
	always_comb begin
		rv_d   = rv_q;
		rst_d  = rst_q;
		rcmd_d = rcmd_q;
		rval_d = rval_q;
		sent   = '0;
		if (take && CMD_DIRECT_I && known) begin
			rv_d   = 1'b1;
			rst_d  = ST_OK;
			rcmd_d = CMD_OPCODE_I;
			rval_d = '0;
			if (is_ext)
				rval_d = EXT_RESULT_I;
			else if (is_reach)
				rval_d = VAL_W'(CMD_VALUE_I[BYTE_W-1:0]);
		end else if (!rv_q && |epend_q) begin
			rv_d   = 1'b1;
			rst_d  = ST_EVENT;
			rcmd_d = OP_REACH_REQ;
			rval_d = VAL_W'(epend_q);
			sent   = epend_q;
		end else if (rv_q && REPLY_READY_I) begin
			rv_d = 1'b0;
		end
		epend_d = (epend_q & ~sent) | ev.fired;
	end

	always_ff @(posedge MCLK_I) begin
		if (SYS_RST_I) begin
			rv_q    <= 1'b0;
			rst_q   <= '0;
			rcmd_q  <= '0;
			rval_q  <= VAL_RST;
			epend_q <= '0;
		end else begin
			rv_q    <= rv_d;
			rst_q   <= rst_d;
			rcmd_q  <= rcmd_d;
			rval_q  <= rval_d;
			epend_q <= epend_d;
		end
	end

	assign REPLY_VALID_O  = rv_q;
	assign REPLY_STATUS_O = rst_q;
	assign REPLY_CMD_O    = rcmd_q;
	assign REPLY_VALUE_O  = rval_q;

	// ==========================================================
	// checks
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (SYS_RST_I);

	vector_store_a: assert property (take && is_define_handler_entry && typ_ok |=>
		vec_q[$past(tidx)] == $past(CMD_VALUE_I[PC_W-1:0]) && vdef_q[$past(tidx)])
		else $error("vector not stored");
	define_handler_entry_ack_a: assert property (take && is_define_handler_entry && CMD_DIRECT_I |=>
		REPLY_VALID_O && REPLY_STATUS_O == ST_OK && REPLY_CMD_O == OP_DEF_ENTRY)
		else $error("vector definition not answered with ok");
	ret_restore_a: assert property (take && is_handler_return && IN_HANDLER_O |=>
		CTX_RESTORE_O && !IN_HANDLER_O && CTX_PC_O == $past(CTX_PC_O))
		else $error("handler return did not restore context");
	ext_answer_a: assert property (EXT_STB_O && CMD_DIRECT_I |=>
		REPLY_STATUS_O == ST_OK && REPLY_VALUE_O == $past(EXT_RESULT_I))
		else $error("extension op answer wrong");
	reach_ack_a: assert property (take && is_reach && CMD_DIRECT_I |=>
		REPLY_CMD_O == OP_REACH_REQ && REPLY_VALUE_O == 32'($past(CMD_VALUE_I[7:0])))
		else $error("reach request ack wrong");
	event_frame_a: assert property (REPLY_VALID_O && REPLY_STATUS_O == ST_EVENT |->
		REPLY_CMD_O == OP_REACH_REQ && REPLY_VALUE_O[VAL_W-1:BYTE_W] == '0)
		else $error("arrival reply frame wrong");
	global_gate_a: assert property (!gen_q |=> !IRQ_JUMP_O)
		else $error("interrupt taken while globally blocked");
	single_handler_a: assert property (IN_HANDLER_O |=> !IRQ_JUMP_O)
		else $error("second handler entered");
	irq_entry_a: assert property (IRQ_JUMP_O |-> IN_HANDLER_O &&
		CTX_PC_O == $past(CTX_PC_I) && IRQ_JUMP_PC_O == $past(vec_q[sel]))
		else $error("interrupt entry context wrong");

	entry_cov: cover property (IRQ_JUMP_O);
	return_cov: cover property (CTX_RESTORE_O);
	event_cov: cover property (REPLY_VALID_O && REPLY_STATUS_O == ST_EVENT);
	ext_cov: cover property (EXT_STB_O);
endmodule // ivme_top

// *** ivme_pkg.sv ***
package ivme_pkg;
	// ==========================================================
	// opcodes
	localparam logic [7:0] OP_IRQ_ENABLE  = 8'h19;
	localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
	localparam logic [7:0] OP_DEF_ENTRY   = 8'h25;
	localparam logic [7:0] OP_HANDLER_RET = 8'h26;
	localparam logic [7:0] OP_EXT_FIRST   = 8'h40;
	localparam logic [7:0] OP_EXT_LAST    = 8'h47;
	localparam logic [7:0] OP_REACH_REQ   = 8'h8a;
	// ==========================================================
	// reply status codes and field values
	localparam logic [7:0] ST_OK          = 8'h64;
	localparam logic [7:0] ST_EVENT       = 8'h80;
	localparam logic [7:0] IRQ_GLOBAL     = 8'hff;
	localparam logic [7:0] REACH_PERSIST  = 8'h01;
	localparam int         VAL_W          = 32;
	localparam int         BYTE_W         = 8;
	// ==========================================================
	// reset values
	localparam logic [31:0] VAL_RST       = 32'h0000_0000;
	localparam logic        GLOBAL_EN_RST = 1'b0;
	// ==========================================================
	// handler state
	typedef enum logic {HS_NORMAL, HS_HANDLER} ivme_hstate_t;
endpackage

// *** ivme_evt_if.sv ***
interface ivme_evt_if #(parameter int MOT_N = 8);
	logic             arm;
	logic [MOT_N-1:0] arm_mask;
	logic             arm_persist;
	logic             mvp_stb;
	logic [MOT_N-1:0] mvp_mask;
	logic [MOT_N-1:0] reached;
	logic [MOT_N-1:0] fired;
	modport core  (output arm, arm_mask, arm_persist, mvp_stb, mvp_mask, reached, input fired);
	modport track (input arm, arm_mask, arm_persist, mvp_stb, mvp_mask, reached, output fired);
endinterface // ivme_evt_if

// *** ivme_evt_track.sv ***
module ivme_evt_track import ivme_pkg::*; #(
	parameter int MOT_N = 8
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// request, move and reach events
	ivme_evt_if.track ev
);
	logic [MOT_N-1:0] armed_q, armed_d;
	logic             persist_q, persist_d;
	logic [MOT_N-1:0] watch_q, watch_d;

	// ==========================================================
	// arming per motor
	always_comb begin
		armed_d   = armed_q;
		persist_d = persist_q;
		watch_d   = watch_q & ~ev.reached;
		if (ev.mvp_stb) begin
			watch_d = watch_d | (ev.mvp_mask & armed_q);
			if (!persist_q)
				armed_d = armed_q & ~ev.mvp_mask;
		end
		if (ev.arm) begin
			armed_d   = ev.arm_mask;
			persist_d = ev.arm_persist;
		end
	end

	assign ev.fired = watch_q & ev.reached;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_q   <= '0;
			persist_q <= 1'b0;
			watch_q   <= '0;
		end else begin
			armed_q   <= armed_d;
			persist_q <= persist_d;
			watch_q   <= watch_d;
		end
	end

	// ==========================================================
	// checks
	single_shot_a: assert property (@(posedge clk_i) disable iff (rst_i)
		!persist_q && !ev.arm && ev.mvp_stb |=> (armed_q & $past(ev.mvp_mask)) == '0)
		else $error("single shot request stayed armed after a move");
	persist_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
		persist_q && !ev.arm |=> armed_q == $past(armed_q))
		else $error("persistent request lost its motors");
	mask_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ev.arm |=> armed_q == $past(ev.arm_mask))
		else $error("motor mask not taken from request");
	reach_cov: cover property (@(posedge clk_i) disable iff (rst_i) |ev.fired);
endmodule // ivme_evt_track

// *** ivme_host.sv ***
module ivme_host import ivme_pkg::*; (
	// clock
	input  wire logic             clk_i,
	// command frames
	output logic                  cmd_valid_o,
	output logic [7:0]            cmd_opcode_o,
	output logic [7:0]            cmd_type_o,
	output logic [VAL_W-1:0]      cmd_value_o,
	output logic                  cmd_direct_o,
	input  wire logic             cmd_ready_i,
	// reply frames
	input  wire logic             reply_valid_i,
	output logic                  reply_ready_o,
	input  wire logic [7:0]       reply_status_i,
	input  wire logic [7:0]       reply_cmd_i,
	input  wire logic [VAL_W-1:0] reply_value_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// extra cycles before a reply is accepted
	int stall;
	initial begin
		stall = 0;
		cmd_valid_o = 1'b0;
		cmd_opcode_o = 8'h00;
		cmd_type_o = 8'h00;
		cmd_value_o = 32'h0;
		cmd_direct_o = 1'b0;
		reply_ready_o = 1'b0;
	end
	// ==========================================================
	// one frame, held until taken; released fields show garbage
	task automatic send(input logic [7:0] op, input logic [7:0] typ,
		input logic [VAL_W-1:0] val, input logic dir);
		@(posedge clk_i);
		cmd_valid_o <= 1'b1;
		cmd_opcode_o <= op;
		cmd_type_o <= typ;
		cmd_value_o <= val;
		cmd_direct_o <= dir;
		do @(negedge clk_i); while (cmd_ready_i !== 1'b1);
		@(posedge clk_i);
		cmd_valid_o <= 1'b0;
		cmd_opcode_o <= ~op;
		cmd_type_o <= ~typ;
		cmd_value_o <= ~val;
		cmd_direct_o <= ~dir;
	endtask
	// ==========================================================
	// wait a bounded time for a reply, then accept it
	task automatic get_reply(output logic ok, output logic [7:0] st,
		output logic [7:0] cm, output logic [VAL_W-1:0] vl);
		int n = 0;
		ok = 1'b0;
		while (n < 40 && !ok) begin
			@(negedge clk_i);
			n++;
			ok = (reply_valid_i === 1'b1);
		end
		st = reply_status_i;
		cm = reply_cmd_i;
		vl = reply_value_i;
		if (ok) begin
			repeat (stall) @(posedge clk_i);
			@(posedge clk_i);
			reply_ready_o <= 1'b1;
			@(posedge clk_i);
			reply_ready_o <= 1'b0;
		end
	endtask
endmodule // ivme_host

// *** irq_vector_and_move_event_bench.sv ***
module irq_vector_and_move_event_bench import ivme_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, cmd_valid, cmd_ready, cmd_direct, reply_valid, reply_ready;
	logic        ext_stb, prog_run, irq_jump, in_handler, ctx_restore, mvp_stb;
	logic [7:0]  cmd_op, cmd_type, reply_st, reply_cmd, flags_i, flags_o, mvp_mask, reached;
	logic [31:0] cmd_value, reply_value, ext_result, accu_i, x_i, accu_o, x_o;
	logic [15:0] irq_evt, pc_i, pc_o, jump_pc;
	int          bad_count, compares, cycles;
	int          ext_seen = 0;

	ivme_top DUT (.MCLK_I(clk), .SYS_RST_I(rst), .CMD_VALID_I(cmd_valid),
		.CMD_READY_O(cmd_ready), .CMD_OPCODE_I(cmd_op), .CMD_TYPE_I(cmd_type),
		.CMD_VALUE_I(cmd_value), .CMD_DIRECT_I(cmd_direct), .REPLY_VALID_O(reply_valid),
		.REPLY_READY_I(reply_ready), .REPLY_STATUS_O(reply_st), .REPLY_CMD_O(reply_cmd),
		.REPLY_VALUE_O(reply_value), .EXT_STB_O(ext_stb), .EXT_RESULT_I(ext_result),
		.IRQ_EVT_I(irq_evt), .PROG_RUN_I(prog_run), .IRQ_JUMP_O(irq_jump),
		.IRQ_JUMP_PC_O(jump_pc), .IN_HANDLER_O(in_handler), .CTX_ACCU_I(accu_i),
		.CTX_X_I(x_i), .CTX_FLAGS_I(flags_i), .CTX_PC_I(pc_i), .CTX_RESTORE_O(ctx_restore),
		.CTX_ACCU_O(accu_o), .CTX_X_O(x_o), .CTX_FLAGS_O(flags_o), .CTX_PC_O(pc_o),
		.MVP_STB_I(mvp_stb), .MVP_MASK_I(mvp_mask), .MOT_REACHED_I(reached));

	ivme_host host (.clk_i(clk), .cmd_valid_o(cmd_valid), .cmd_opcode_o(cmd_op),
		.cmd_type_o(cmd_type), .cmd_value_o(cmd_value), .cmd_direct_o(cmd_direct),
		.cmd_ready_i(cmd_ready), .reply_valid_i(reply_valid), .reply_ready_o(reply_ready),
		.reply_status_i(reply_st), .reply_cmd_i(reply_cmd), .reply_value_i(reply_value));

	always #5 clk = ~clk;
	// extension strobes seen by the bench
	always @(posedge clk) begin
		if (ext_stb === 1'b1)
			ext_seen++;
	end
	// ==========================================================
	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	// ==========================================================
	// common tasks
	task automatic print_verdict();
		$display("comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t ns: %s", $time, what);
		end
	endtask
	task automatic ack(input logic [7:0] op, input logic [31:0] exp);
		logic ok;
		logic [7:0] st, cm;
		logic [31:0] vl;
		host.get_reply(ok, st, cm, vl);
		check(ok, 1, "acknowledge missing");
		check(st, ST_OK, "acknowledge status");
		check(cm, op, "acknowledge command");
		check(vl, exp, "acknowledge value");
	endtask
	task automatic cmd(input logic [7:0] op, input logic [7:0] typ, input logic [31:0] val,
		input logic dir, input logic [31:0] exp);
		host.send(op, typ, val, dir);
		if (dir)
			ack(op, exp);
	endtask
	task automatic expect_event(input logic exp, input logic [7:0] mask);
		logic ok;
		logic [7:0] st, cm;
		logic [31:0] vl;
		host.get_reply(ok, st, cm, vl);
		check(ok, exp, "reply presence");
		if (ok && exp) begin
			check(st, ST_EVENT, "arrival status");
			check(cm, OP_REACH_REQ, "arrival command");
			check(vl, {24'h0, mask}, "arrival mask");
		end
	endtask
	task automatic pulse_irq(input int n);
		@(posedge clk);
		irq_evt <= 16'h0001 << n;
		@(posedge clk);
		irq_evt <= 16'h0000;
	endtask
	task automatic pulse_move(input logic [7:0] mv, input logic [7:0] rc);
		@(posedge clk);
		mvp_stb <= 1'b1;
		mvp_mask <= mv;
		@(posedge clk);
		mvp_stb <= 1'b0;
		repeat (2) @(posedge clk);
		reached <= rc;
		@(posedge clk);
		reached <= 8'h00;
	endtask
	task automatic wait_jump(input logic exp, input logic [15:0] pc);
		logic seen = 1'b0;
		repeat (8) begin
			@(negedge clk);
			if (irq_jump === 1'b1 && !seen) begin
				seen = 1'b1;
				check(jump_pc, pc, "jump target");
			end
		end
		check(seen, exp, "jump occurrence");
	endtask
	// ==========================================================
	// scenarios
	task automatic t_irq();
		@(posedge clk);
		accu_i <= 32'h1111_2222;
		x_i <= 32'h3333_4444;
		flags_i <= 8'h5a;
		pc_i <= 16'h0123;
		prog_run <= 1'b1;
		cmd(OP_DEF_ENTRY, 8'h03, 32'h32, 1'b1, 32'h0);
		cmd(OP_DEF_ENTRY, 8'h03, 32'h40, 1'b0, 32'h0);
		cmd(OP_IRQ_ENABLE, 8'h03, 32'h0, 1'b1, 32'h0);
		cmd(OP_IRQ_ENABLE, IRQ_GLOBAL, 32'h0, 1'b1, 32'h0);
		pulse_irq(3);
		wait_jump(1'b1, 16'h0040);
		check(in_handler, 1, "handler active");
		@(posedge clk);
		accu_i <= 32'h9999_0000;
		pc_i <= 16'h0456;
		pulse_irq(3);
		wait_jump(1'b0, 16'h0);
		host.send(OP_HANDLER_RET, 8'h00, 32'h0, 1'b1);
		@(negedge clk);
		check(ctx_restore, 1, "restore strobe");
		check(accu_o, 32'h1111_2222, "restored accumulator");
		check(x_o, 32'h3333_4444, "restored x");
		check(flags_o, 8'h5a, "restored flags");
		check(pc_o, 16'h0123, "restored pc");
		wait_jump(1'b1, 16'h0040);
		ack(OP_HANDLER_RET, 32'h0);
		cmd(OP_HANDLER_RET, 8'h00, 32'h0, 1'b0, 32'h0);
		@(negedge clk);
		check(in_handler, 0, "handler left");
		cmd(OP_IRQ_DISABLE, IRQ_GLOBAL, 32'h0, 1'b1, 32'h0);
		pulse_irq(3);
		wait_jump(1'b0, 16'h0);
		$display("test interrupts done");
	endtask
	task automatic t_ext();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			ext_result <= 32'h5a5a_0000 + i;
			cmd(OP_EXT_FIRST + 8'(i), 8'(i), 32'h0, 1'b1, 32'h5a5a_0000 + i);
		end
		host.send(OP_EXT_LAST + 8'h01, 8'h00, 32'h0, 1'b1);
		expect_event(1'b0, 8'h00);
		check(ext_seen, 8, "extension strobe count");
		$display("test extension ops done");
	endtask
	task automatic t_reach_once();
		cmd(OP_REACH_REQ, 8'h00, 32'h05, 1'b1, 32'h05);
		pulse_move(8'h05, 8'h05);
		expect_event(1'b1, 8'h05);
		pulse_move(8'h05, 8'h05);
		expect_event(1'b0, 8'h00);
		$display("test single report done");
	endtask
	task automatic t_reach_every();
		host.stall = 3;
		cmd(OP_REACH_REQ, REACH_PERSIST, 32'h02, 1'b1, 32'h02);
		repeat (2) begin
			pulse_move(8'h03, 8'h03);
			expect_event(1'b1, 8'h02);
		end
		host.stall = 0;
		$display("test persistent report done");
	endtask
	// ==========================================================
	// main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ext_result = 32'h0;
		irq_evt = 16'h0;
		prog_run = 1'b0;
		accu_i = 32'h0;
		x_i = 32'h0;
		flags_i = 8'h00;
		pc_i = 16'h0;
		mvp_stb = 1'b0;
		mvp_mask = 8'h00;
		reached = 8'h00;
		bad_count = 0;
		compares = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check(reply_valid, 0, "reply idle after reset");
		check(cmd_ready, 1, "ready after reset");
		check(in_handler, 0, "no handler after reset");
		t_irq();
		t_ext();
		t_reach_once();
		t_reach_every();
		print_verdict();
	end
endmodule // irq_vector_and_move_event_bench
